// ### ddi_params.svh
`ifndef DDI_PARAMS_SVH
`define DDI_PARAMS_SVH

// Register offsets (word index on the plain register port)
`define DDI_OFS_STATUS      8'h00
`define DDI_OFS_CONTROL     8'h01
`define DDI_OFS_INVERT      8'h02
`define DDI_OFS_ROUTE_BASE  8'h10
`define DDI_OFS_ROUTE_LAST  8'h18

// Control register fields
`define DDI_CTL_FMD         0
`define DDI_CTL_ALLOW_LO    1
`define DDI_CTL_ALLOW_HI    4
`define DDI_CTL_SW_REF      5
`define DDI_CTL_SW_REV      6
`define DDI_CTL_SW_INCH     7

// Reset values
`define DDI_CONTROL_RESET   8'h00
`define DDI_INVERT_RESET    9'h000
`define DDI_ROUTE_RESET     11'h000

// Route codes
`define DDI_ROUTE_MAX       11'h07CF
`define DDI_DEST_REF_ON     11'h006F
`define DDI_DEST_REVERSE    11'h0070
`define DDI_DEST_INCH       11'h0071
`define DDI_ROUTE_DEPTH     9
`define DDI_ROUTE_LAST_IDX  4'h8

// Timing
`define DDI_CLK_HZ          40000000
`define DDI_ENOFF_MS        30
`define DDI_ENOFF_CYCLES    ((`DDI_ENOFF_MS * `DDI_CLK_HZ) / 1000)
`define DDI_ENOFF_CNT_W     21

`endif

// ### ddi_pkg.sv
package ddi_pkg;
    typedef logic [10:0] ddi_dest_t;
    typedef enum logic [1:0] {
        DDI_IDLE  = 2'b00,
        DDI_READ  = 2'b01,
        DDI_STORE = 2'b10
    } ddi_walk_t;
endpackage : ddi_pkg

// ### ddi_in_sync.sv
`timescale 1ns/100ps
`include "ddi_params.svh"
module ddi_in_sync (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic [10:0] raw,
    input  wire logic [10:0] inv,
    output logic      [10:0] q
);
    logic [10:0] meta;
    logic [10:0] stable;

    // Terminal contacts are asynchronous; the first stage feeds only the second
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            meta   <= 11'h000;
            stable <= 11'h000;
        end else begin
            meta   <= raw;
            stable <= meta;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q <= 11'h000;
        end else begin
            q <= stable ^ inv;
        end
    end
endmodule : ddi_in_sync

// ### ddi_route_mem.sv
`timescale 1ns/100ps
`include "ddi_params.svh"
module ddi_route_mem
    import ddi_pkg::*;
(
    input  wire logic      core_clk,
    input  wire logic      rstn,
    input  wire logic      wr_en,
    input  wire logic [3:0] wr_addr,
    input  wire ddi_dest_t wr_data,
    input  wire logic      rd_en,
    input  wire logic [3:0] rd_addr,
    output ddi_dest_t      rd_data
);
    ddi_dest_t mem [`DDI_ROUTE_DEPTH];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < `DDI_ROUTE_DEPTH; i++) begin
                mem[i] <= `DDI_ROUTE_RESET;
            end
        end else if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= `DDI_ROUTE_RESET;
        end else if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : ddi_route_mem

// ### ddi_top.sv
`timescale 1ns/100ps
`include "ddi_params.svh"
module ddi_top
    import ddi_pkg::*;
#(
    parameter int unsigned ENOFF_CYCLES = `DDI_ENOFF_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        run_permit_input,
    input  wire logic        second_control_input,
    input  wire logic        third_control_input,
    input  wire logic        fourth_control_input,
    input  wire logic        fifth_control_input,
    input  wire logic        sixth_control_input,
    input  wire logic        seventh_control_input,
    input  wire logic        eighth_control_input,
    input  wire logic        ninth_control_input,
    input  wire logic        tenth_control_input,
    input  wire logic        hw_enable_input,
    input  wire logic        param_reset_button,
    input  wire logic        ramp_hold,
    input  wire logic        drive_running,
    output logic             start_allowed,
    output logic             pre_ramp_ref_zero,
    output logic             stop_request,
    output logic             ref_on,
    output logic             reverse_sel,
    output logic             inch_rev_cmd,
    output logic             inch_fwd_cmd,
    output logic             run_rev_cmd,
    output logic             run_fwd_cmd,
    output logic             firing_enable,
    output logic             coast_stop,
    output logic             ramp_reset,
    output logic      [3:0]  route_index,
    output ddi_dest_t        route_dest,
    output logic             route_level
);

    ////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic is_route_addr(input logic [7:0] a);
        is_route_addr = (a >= `DDI_OFS_ROUTE_BASE) && (a <= `DDI_OFS_ROUTE_LAST);
    endfunction : is_route_addr

    function automatic logic dest_hit(input logic [8:0] lv, input ddi_dest_t tbl [9],
                                      input ddi_dest_t code);
        logic h;
        h = 1'b0;
        for (int i = 0; i < 9; i++) begin
            h = h | (lv[i] & (tbl[i] == code));
        end
        dest_hit = h;
    endfunction : dest_hit

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [7:0]  control;
    logic [8:0]  invert;
    logic [10:0] s;
    logic        permit;
    logic        en;
    logic        norm;
    logic        ok;
    logic        fmd;
    logic [3:0]  allow;
    logic        sw_ref;
    logic        sw_rev;
    logic        sw_inch;
    ddi_dest_t   active [9];
    ddi_dest_t   mem_q;
    logic        mem_rd;
    logic [3:0]  mem_rd_addr;
    logic [7:0]  route_ofs;
    logic        sw_route_rd;
    logic        sw_route_wr;
    ddi_walk_t   walk;
    logic [3:0]  walk_idx;
    logic        load_pend;
    logic        ref_q;
    logic        rev_q;
    logic        prog_ref;
    logic        prog_rev;
    logic        prog_inch;
    logic        inch_sel;
    logic        next_inch_rev;
    logic        next_inch_fwd;
    logic        next_run_rev;
    logic        next_run_fwd;
    logic        en_prev;
    logic        en_fall;
    logic [`DDI_ENOFF_CNT_W-1:0] off_cnt;
    logic [15:0] rd_q;
    logic        rd_route_q;
    logic [3:0]  scan_idx;

    ////////////////////////////////////////////////////////////////////////
    // Input stage

    ddi_in_sync u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .raw      ({hw_enable_input, tenth_control_input, ninth_control_input,
                    eighth_control_input, seventh_control_input, sixth_control_input,
                    fifth_control_input, fourth_control_input, third_control_input,
                    second_control_input, run_permit_input}),
        .inv      ({1'b0, invert, 1'b0}),
        .q        (s)
    );

    assign permit  = s[0];
    assign en      = s[10];
    assign fmd     = control[`DDI_CTL_FMD];
    assign norm    = ~fmd;
    assign allow   = control[`DDI_CTL_ALLOW_HI:`DDI_CTL_ALLOW_LO];
    assign sw_ref  = control[`DDI_CTL_SW_REF];
    assign sw_rev  = control[`DDI_CTL_SW_REV];
    assign sw_inch = control[`DDI_CTL_SW_INCH];
    assign ok      = permit & en;

    ////////////////////////////////////////////////////////////////////////
    // Register writes

    assign route_ofs   = reg_addr - `DDI_OFS_ROUTE_BASE;
    assign sw_route_wr = reg_wr & is_route_addr(reg_addr) & (reg_wdata[15:11] == 5'h00)
                         & (reg_wdata[10:0] <= `DDI_ROUTE_MAX);
    assign sw_route_rd = reg_rd & is_route_addr(reg_addr);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            control <= `DDI_CONTROL_RESET;
        end else if (reg_wr && reg_addr == `DDI_OFS_CONTROL) begin
            control <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            invert <= `DDI_INVERT_RESET;
        end else if (reg_wr && reg_addr == `DDI_OFS_INVERT) begin
            invert <= reg_wdata[8:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Route store: software edits the pending copy, the button applies it

    assign mem_rd      = sw_route_rd | (walk == DDI_READ);
    assign mem_rd_addr = sw_route_rd ? route_ofs[3:0] : walk_idx;

    ddi_route_mem u_mem (
        .core_clk (core_clk),
        .rstn     (rstn),
        .wr_en    (sw_route_wr),
        .wr_addr  (route_ofs[3:0]),
        .wr_data  (reg_wdata[10:0]),
        .rd_en    (mem_rd),
        .rd_addr  (mem_rd_addr),
        .rd_data  (mem_q)
    );

    // Software reads win the memory port; the walker simply waits
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            walk      <= DDI_IDLE;
            walk_idx  <= 4'h0;
            load_pend <= 1'b0;
        end else begin
            case (walk)
                DDI_IDLE: begin
                    walk_idx <= 4'h0;
                    if (param_reset_button || load_pend) begin
                        walk      <= DDI_READ;
                        load_pend <= 1'b0;
                    end
                end
                DDI_READ: begin
                    if (param_reset_button) begin
                        load_pend <= 1'b1;
                    end
                    if (!sw_route_rd) begin
                        walk <= DDI_STORE;
                    end
                end
                DDI_STORE: begin
                    if (param_reset_button) begin
                        load_pend <= 1'b1;
                    end
                    if (walk_idx == `DDI_ROUTE_LAST_IDX) begin
                        walk <= DDI_IDLE;
                    end else begin
                        walk_idx <= walk_idx + 4'h1;
                        walk     <= DDI_READ;
                    end
                end
                default: begin
                    walk <= DDI_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 9; i++) begin
                active[i] <= `DDI_ROUTE_RESET;
            end
        end else if (walk == DDI_STORE) begin
            active[walk_idx] <= mem_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Routed destinations, one input per cycle

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            scan_idx    <= 4'h0;
            route_index <= 4'h0;
            route_dest  <= `DDI_ROUTE_RESET;
            route_level <= 1'b0;
        end else begin
            scan_idx    <= (scan_idx == `DDI_ROUTE_LAST_IDX) ? 4'h0 : scan_idx + 4'h1;
            route_index <= scan_idx;
            route_dest  <= active[scan_idx];
            route_level <= s[scan_idx + 4'h1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command logic

    assign prog_ref  = dest_hit(s[9:1], active, `DDI_DEST_REF_ON);
    assign prog_rev  = dest_hit(s[9:1], active, `DDI_DEST_REVERSE);
    assign prog_inch = dest_hit(s[9:1], active, `DDI_DEST_INCH);
    assign inch_sel  = prog_inch | sw_inch;

    // Reference-on; gated by permit and enable in both modes
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ref_q <= 1'b0;
        end else if (!ok) begin
            ref_q <= 1'b0;
        end else if (norm) begin
            if (s[3] | s[4]) begin
                ref_q <= 1'b1;
            end
        end else begin
            ref_q <= (prog_ref & permit) | sw_ref;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rev_q <= 1'b0;
        end else if (norm) begin
            if (s[3] & ~s[4]) begin
                rev_q <= 1'b1;
            end else if (s[4] & ~s[3]) begin
                rev_q <= 1'b0;
            end
        end else begin
            rev_q <= prog_rev | sw_rev;
        end
    end

    always_comb begin
        if (norm) begin
            next_inch_rev = ok & ~ref_q & s[1] & ~s[2];
            next_inch_fwd = ok & ~ref_q & s[2] & ~s[1];
            next_run_rev  = ok & ref_q & rev_q;
            next_run_fwd  = ok & ref_q & ~rev_q;
        end else begin
            next_inch_rev = ok & ref_q & inch_sel & rev_q & allow[0];
            next_inch_fwd = ok & ref_q & inch_sel & ~rev_q & allow[1];
            next_run_rev  = ok & ref_q & ~inch_sel & rev_q & allow[2];
            next_run_fwd  = ok & ref_q & ~inch_sel & ~rev_q & allow[3];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            inch_rev_cmd <= 1'b0;
            inch_fwd_cmd <= 1'b0;
            run_rev_cmd  <= 1'b0;
            run_fwd_cmd  <= 1'b0;
        end else begin
            inch_rev_cmd <= next_inch_rev;
            inch_fwd_cmd <= next_inch_fwd;
            run_rev_cmd  <= next_run_rev;
            run_fwd_cmd  <= next_run_fwd;
        end
    end

    assign ref_on            = ref_q;
    assign reverse_sel       = rev_q;
    assign start_allowed     = ok;
    assign pre_ramp_ref_zero = ~permit;
    assign stop_request      = ~permit & ~ramp_hold;

    ////////////////////////////////////////////////////////////////////////
    // Enable loss: delayed firing off, coast stop

    assign en_fall = en_prev & ~en;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            en_prev <= 1'b0;
        end else begin
            en_prev <= en;
        end
    end

    // Pulses stay on through the delay so the bridge is not cut mid-conduction
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            firing_enable <= 1'b0;
            off_cnt       <= '0;
        end else if (en) begin
            firing_enable <= 1'b1;
            off_cnt       <= '0;
        end else if (firing_enable) begin
            if (off_cnt == `DDI_ENOFF_CNT_W'(ENOFF_CYCLES - 1)) begin
                firing_enable <= 1'b0;
            end else begin
                off_cnt <= off_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            coast_stop <= 1'b0;
            ramp_reset <= 1'b0;
        end else begin
            ramp_reset <= en_fall & drive_running;
            if (en_fall && drive_running) begin
                coast_stop <= 1'b1;
            end else if (en) begin
                coast_stop <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_q       <= 16'h0000;
            rd_route_q <= 1'b0;
        end else begin
            rd_route_q <= sw_route_rd;
            rd_q       <= 16'h0000;
            if (reg_rd) begin
                case (reg_addr)
                    `DDI_OFS_STATUS:  rd_q <= {2'b00, coast_stop, firing_enable, ref_q, s};
                    `DDI_OFS_CONTROL: rd_q <= {8'h00, control};
                    `DDI_OFS_INVERT:  rd_q <= {7'h00, invert};
                    default:          rd_q <= 16'h0000;
                endcase
            end
        end
    end

    assign reg_rdata = rd_route_q ? {5'h00, mem_q} : rd_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_permit_ref_zero: assert property (!permit |-> pre_ramp_ref_zero && !start_allowed)
        else $error("Reference not zeroed without permit");
    a_no_start_permit: assert property (!permit |=> !ref_on ##1 !run_rev_cmd && !run_fwd_cmd)
        else $error("Run active without permit");
    a_hold_stop: assert property (!permit && ramp_hold |-> !stop_request)
        else $error("Stop despite ramp hold");
    a_run_latch: assert property (ref_q && norm && ok |=> ref_q)
        else $error("Reference-on dropped in fixed mode");
    a_run_fwd_set: assert property (norm && ok && s[4] && !s[3] |=> ref_q ##1 run_fwd_cmd || !ok)
        else $error("Run forward not taken");
    a_inch_fixed: assert property (norm && ok && !ref_q && s[1] && !s[2] |=> inch_rev_cmd)
        else $error("Inch reverse not taken");
    a_user_allow: assert property (!norm && !allow[2] |=> !run_rev_cmd)
        else $error("Run reverse without allow bit");
    a_coast_stop: assert property (en_fall && drive_running |=> coast_stop && ramp_reset ##1 !ramp_reset)
        else $error("Coast stop missing");
    a_fire_drop: assert property (!en && firing_enable && off_cnt == `DDI_ENOFF_CNT_W'(ENOFF_CYCLES - 1)
                                  |=> !firing_enable)
        else $error("Firing not removed after delay");
    a_fire_hold: assert property (en_fall |=> firing_enable [*2])
        else $error("Firing removed early");

endmodule : ddi_top

// ### ddi_contacts.sv
`timescale 1ns/100ps
// Terminal contacts at the drive's input block.
// Contacts bounce free of the core clock, so every level change lands 3 ns off the edge.
module ddi_contacts (
    input  wire logic [10:0] level,
    output logic             run_permit_input,
    output logic             second_control_input,
    output logic             third_control_input,
    output logic             fourth_control_input,
    output logic             fifth_control_input,
    output logic             sixth_control_input,
    output logic             seventh_control_input,
    output logic             eighth_control_input,
    output logic             ninth_control_input,
    output logic             tenth_control_input,
    output logic             hw_enable_input
);
    ////////////////////////////////////////////////////////////////////////////////
    // Unrelated to the clock phase, so the design must synchronise
    assign #3 {hw_enable_input, tenth_control_input, ninth_control_input, eighth_control_input,
               seventh_control_input, sixth_control_input, fifth_control_input, fourth_control_input,
               third_control_input, second_control_input, run_permit_input} = level;
endmodule : ddi_contacts

// ### tb.sv
`timescale 1ns/100ps
module tb;
    import ddi_pkg::*;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [10:0] term = 11'h000;
    logic        btn = 1'b0;
    logic        ramp_hold = 1'b0;
    logic        drive_running = 1'b0;
    logic        p1, i2, i3, i4, i5, i6, i7, i8, i9, i10, en;
    logic        start_allowed, pre_ramp_ref_zero, stop_request, ref_on, reverse_sel;
    logic        inch_rev_cmd, inch_fwd_cmd, run_rev_cmd, run_fwd_cmd, firing_enable, coast_stop;
    logic [8:0]  inv;
    logic        ramp_rst;
    logic [3:0]  r_idx;
    ddi_dest_t   r_dest;
    logic        r_lvl;
    logic        saw_ramp = 1'b0;
    logic [8:0]  seen = 9'h000;
    int          n_errors = 0;
    int          checked = 0;
    localparam int unsigned ENOFF = 20;
    always #12.5 core_clk = ~core_clk;
    ddi_contacts u_contacts (.level(term), .run_permit_input(p1), .second_control_input(i2),
        .third_control_input(i3), .fourth_control_input(i4), .fifth_control_input(i5),
        .sixth_control_input(i6), .seventh_control_input(i7), .eighth_control_input(i8),
        .ninth_control_input(i9), .tenth_control_input(i10), .hw_enable_input(en));
    ddi_top #(.ENOFF_CYCLES(ENOFF)) dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .run_permit_input(p1), .second_control_input(i2), .third_control_input(i3),
        .fourth_control_input(i4), .fifth_control_input(i5), .sixth_control_input(i6),
        .seventh_control_input(i7), .eighth_control_input(i8), .ninth_control_input(i9),
        .tenth_control_input(i10), .hw_enable_input(en), .param_reset_button(btn),
        .ramp_hold(ramp_hold), .drive_running(drive_running), .start_allowed(start_allowed),
        .pre_ramp_ref_zero(pre_ramp_ref_zero), .stop_request(stop_request), .ref_on(ref_on),
        .reverse_sel(reverse_sel), .inch_rev_cmd(inch_rev_cmd), .inch_fwd_cmd(inch_fwd_cmd),
        .run_rev_cmd(run_rev_cmd), .run_fwd_cmd(run_fwd_cmd), .firing_enable(firing_enable),
        .coast_stop(coast_stop), .ramp_reset(ramp_rst), .route_index(r_idx),
        .route_dest(r_dest), .route_level(r_lvl));
    // The ramp reset pulse lasts one cycle, so it is caught here and checked later
    always @(posedge core_clk) begin
        if (ramp_rst) begin
            saw_ramp <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [10:0] exp_status(input logic [10:0] t, input logic [8:0] iv);
        return {t[10], t[9:1] ^ iv, t[0]};
    endfunction : exp_status
    function automatic logic [15:0] exp_route(input logic [3:0] idx);
        return (idx == 4'h0) ? 16'd111 : (idx == 4'h8) ? 16'd1999 : 16'h0000;
    endfunction : exp_route
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_val
    task automatic chk_bit(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe, so it is sampled there
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [15:0] exp,
                          input logic [15:0] mask);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        chk_val(name, exp & mask, reg_rdata & mask);
    endtask : rd_chk
    task automatic drive(input logic [10:0] t);
        @(posedge core_clk);
        term <= t;
        settle(7);
    endtask : drive
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(25 * 20000);
        n_errors++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h3e6c));
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        rd_chk("control reset", 8'h01, 16'h0000, 16'hffff);
        rd_chk("invert reset", 8'h02, 16'h0000, 16'hffff);
        rd_chk("route reset", 8'h14, 16'h0000, 16'hffff);
        rd_chk("unmapped", 8'h05, 16'h0000, 16'hffff);
        for (int k = 0; k < 10; k++) begin
            inv = (k < 2) ? 9'h000 : 9'($urandom);
            wr(8'h02, {7'h00, inv});
            @(posedge core_clk);
            ramp_hold <= 1'($urandom);
            drive({(k == 0) ? 11'h7ff : (k == 1) ? 11'h000 : 11'($urandom)});
            rd_chk("status", 8'h00, {5'h00, exp_status(term, inv)}, 16'h07ff);
            chk_bit("start_allowed", term[0] & term[10], start_allowed);
            chk_bit("pre_ramp_ref_zero", ~term[0], pre_ramp_ref_zero);
            chk_bit("stop_request", ~term[0] & ~ramp_hold, stop_request);
        end
        wr(8'h02, 16'h0000);
        // Random phase may have latched reference-on; dropping permit clears it
        drive(11'h400);
        drive(11'h401);
        chk_bit("ref idle", 1'b0, ref_on);
        drive(11'h403);
        chk_bit("inch rev", 1'b1, inch_rev_cmd);
        drive(11'h405);
        chk_bit("inch fwd", 1'b1, inch_fwd_cmd);
        drive(11'h411);
        chk_bit("run fwd", 1'b1, run_fwd_cmd);
        drive(11'h401);
        chk_bit("ref latched", 1'b1, ref_on);
        drive(11'h400);
        chk_bit("ref dropped", 1'b0, ref_on);
        drive(11'h409);
        chk_bit("run rev dir", 1'b1, reverse_sel);
        drive(11'h401);
        // Routes: out of range refused, new values wait for the parameter reset
        wr(8'h10, 16'd111);
        wr(8'h10, 16'd2000);
        rd_chk("route refused", 8'h10, 16'd111, 16'hffff);
        wr(8'h18, 16'd1999);
        rd_chk("route max", 8'h18, 16'd1999, 16'hffff);
        wr(8'h01, 16'h0001);
        drive(11'h400);
        drive(11'h403);
        chk_bit("route pending", 1'b0, ref_on);
        chk_bit("inch rev user", 1'b0, inch_rev_cmd);
        @(posedge core_clk);
        btn <= 1'b1;
        @(posedge core_clk);
        btn <= 1'b0;
        settle(40);
        chk_bit("routed ref", 1'b1, ref_on);
        for (int c = 0; c < 9; c++) begin
            settle(1);
            seen = seen | (9'h001 << r_idx);
            chk_val("route dest", exp_route(r_idx), {5'h00, r_dest});
            chk_bit("route level", r_idx == 4'h0, r_lvl);
        end
        chk_val("route index", 16'h01ff, {7'h00, seen});
        drive(11'h402);
        chk_bit("routed no permit", 1'b0, ref_on);
        // Software reference-on still needs permit, or a start would slip past it
        drive(11'h401);
        wr(8'h01, 16'h0061);
        settle(3);
        chk_bit("sw ref", 1'b1, ref_on);
        chk_bit("sw reverse", 1'b1, reverse_sel);
        chk_bit("run rev no allow", 1'b0, run_rev_cmd);
        wr(8'h01, 16'h0069);
        settle(3);
        chk_bit("user run rev", 1'b1, run_rev_cmd);
        wr(8'h01, 16'h00e3);
        settle(3);
        chk_bit("user inch rev", 1'b1, inch_rev_cmd);
        wr(8'h01, 16'h0000);
        drive(11'h401);
        chk_bit("firing on", 1'b1, firing_enable);
        @(posedge core_clk);
        drive_running <= 1'b1;
        term <= 11'h001;
        settle(ENOFF - 4);
        chk_bit("firing held", 1'b1, firing_enable);
        settle(12);
        chk_bit("firing off", 1'b0, firing_enable);
        chk_bit("coast", 1'b1, coast_stop);
        chk_bit("ramp reset", 1'b1, saw_ramp);
        stop_test();
    end
endmodule : tb
